// ### low_battery_params.svh
`ifndef LOW_BATTERY_PARAMS_SVH
`define LOW_BATTERY_PARAMS_SVH

// register byte offsets on the bus
`define LB_OFF_WAKE_STS   8'h00
`define LB_OFF_WAKE_EN    8'h04
`define LB_OFF_SMI_STS    8'h08
`define LB_OFF_SMI_EN     8'h0C
`define LB_OFF_POWER      8'h10
`define LB_OFF_IRQ_STS    8'h14
`define LB_OFF_IRQ_MASK   8'h18

// field positions
`define LB_BIT_LOWBAT     0
`define LB_BIT_GROUP_EN   1
`define LB_BIT_IRQ_BPOR   0
`define LB_BIT_IRQ_MAIN   1

// reset values
`define LB_RST_STS        1'h0
`define LB_RST_EN         2'h0
`define LB_RST_IRQ        2'h0

// synchroniser depth in cycles
`define LB_SYNC_STAGES    2

`endif

// ### low_battery_pkg.sv
package low_battery_pkg;

  // supply condition of the part, as seen after synchronisation
  typedef enum logic [1:0] {
    PM_BATTERY_ONLY,
    PM_STANDBY,
    PM_MAIN
  } power_mode_t;

  // fixed widths of the block
  typedef logic [1:0] enable_t;
  typedef logic [3:0] sync_vec_t;

endpackage : low_battery_pkg

// ### battery_sync.sv
`timescale 1ns/10ps
`include "low_battery_params.svh"

// two-flop synchroniser for the pin levels
module battery_sync (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire low_battery_pkg::sync_vec_t async_in,
  output low_battery_pkg::sync_vec_t       sync_out
);

  low_battery_pkg::sync_vec_t meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r   <= 4'h0;
      sync_out <= 4'h0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : battery_sync

// ### low_battery_event_logic.sv
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "low_battery_params.svh"

// Contract
// - two comparator levels, below upper and below lower, feed the status logic
// - battery only and below lower gives a battery POR at standby POR
// - below upper off main power sets wake and smi status at main POR
// - battery POR sets both wake and smi low battery status bits to one
// - wake enable clears on standby POR, so battery POR never wakes
// - events raised only with main power, status, enable and group enable set
// - internal battery low event becomes active only at main POR
// - no wake event off main power; enables set earlier act once main returns
// - smi enables set earlier raise smi once main power returns
// - status bits not set while on main power, only at main POR or battery POR
// - smi status and enable bits beside matching wake status and enable
module low_battery_event_logic (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        battery_below_upper,
  input  wire logic        battery_below_lower,
  input  wire logic        standby_power_good,
  input  wire logic        main_power_good,
  output logic             wake_event,
  output logic             smi_event,
  output logic             battery_por,
  output logic             irq
);

  low_battery_pkg::sync_vec_t   pins_s;
  low_battery_pkg::power_mode_t mode_r;
  low_battery_pkg::power_mode_t mode_nxt;
  low_battery_pkg::enable_t     wake_en_r;
  low_battery_pkg::enable_t     smi_en_r;
  logic       below_upper_s;
  logic       below_lower_s;
  logic       standby_s;
  logic       main_s;
  logic       standby_por;
  logic       main_por;
  logic       bpor;
  logic       battery_low_event;
  logic       low_lower_seen_r;
  logic       low_upper_seen_r;
  logic       wake_status_reg_r;
  logic       smi_status_reg_r;
  logic [1:0] irq_sts_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_set;
  logic       acc;
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       wr_wake_sts;
  logic       wr_smi_sts;
  logic       wr_irq_sts;
  logic       wr_wake_en;
  logic       wr_smi_en;
  logic       wr_irq_mask;

  // comparator and supply pins into the clock domain
  battery_sync u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({main_power_good, standby_power_good,
                battery_below_lower, battery_below_upper}),
    .sync_out (pins_s)
  );

  assign below_upper_s = pins_s[0];
  assign below_lower_s = pins_s[1];
  assign standby_s     = pins_s[2];
  assign main_s        = pins_s[3];

  // supply mode tracking; main only entered through standby
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      low_battery_pkg::PM_BATTERY_ONLY: begin
        if (standby_s) begin
          mode_nxt = low_battery_pkg::PM_STANDBY;
        end
      end
      low_battery_pkg::PM_STANDBY: begin
        if (!standby_s) begin
          mode_nxt = low_battery_pkg::PM_BATTERY_ONLY;
        end else if (main_s) begin
          mode_nxt = low_battery_pkg::PM_MAIN;
        end
      end
      low_battery_pkg::PM_MAIN: begin
        if (!standby_s) begin
          mode_nxt = low_battery_pkg::PM_BATTERY_ONLY;
        end else if (!main_s) begin
          mode_nxt = low_battery_pkg::PM_STANDBY;
        end
      end
      default: begin
        mode_nxt = low_battery_pkg::PM_BATTERY_ONLY;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= low_battery_pkg::PM_BATTERY_ONLY;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // power-on reset pulses from mode transitions
  assign standby_por = (mode_r == low_battery_pkg::PM_BATTERY_ONLY) && standby_s;
  assign main_por    = (mode_r == low_battery_pkg::PM_STANDBY) && standby_s && main_s;
  assign bpor        = standby_por && low_lower_seen_r;

  // lower threshold seen while on battery only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_lower_seen_r <= 1'b0;
    end else if (standby_por) begin
      low_lower_seen_r <= 1'b0;
    end else if (mode_r == low_battery_pkg::PM_BATTERY_ONLY && below_lower_s) begin
      low_lower_seen_r <= 1'b1;
    end
  end

  // upper threshold seen while main power is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_upper_seen_r <= 1'b0;
    end else if (main_por) begin
      low_upper_seen_r <= 1'b0;
    end else if (mode_r != low_battery_pkg::PM_MAIN && below_upper_s) begin
      low_upper_seen_r <= 1'b1;
    end
  end

  // battery low event only at main power-on reset
  assign battery_low_event = main_por && (low_upper_seen_r || below_upper_s);

  // bus address phase decode
  assign acc         = hsel && hready && htrans[1];
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign wr_wake_sts = wr_pend_r && (wr_addr_r == `LB_OFF_WAKE_STS);
  assign wr_smi_sts  = wr_pend_r && (wr_addr_r == `LB_OFF_SMI_STS);
  assign wr_irq_sts  = wr_pend_r && (wr_addr_r == `LB_OFF_IRQ_STS);
  assign wr_wake_en  = wr_pend_r && (wr_addr_r == `LB_OFF_WAKE_EN);
  assign wr_smi_en   = wr_pend_r && (wr_addr_r == `LB_OFF_SMI_EN);
  assign wr_irq_mask = wr_pend_r && (wr_addr_r == `LB_OFF_IRQ_MASK);

  // register read mux
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      `LB_OFF_WAKE_STS: d[`LB_BIT_LOWBAT] = wake_status_reg_r;
      `LB_OFF_WAKE_EN:  d[1:0] = wake_en_r;
      `LB_OFF_SMI_STS:  d[`LB_BIT_LOWBAT] = smi_status_reg_r;
      `LB_OFF_SMI_EN:   d[1:0] = smi_en_r;
      `LB_OFF_POWER:    d[5:0] = {low_upper_seen_r, low_lower_seen_r, main_s,
                                  standby_s, below_lower_s, below_upper_s};
      `LB_OFF_IRQ_STS:  d[1:0] = irq_sts_r;
      `LB_OFF_IRQ_MASK: d[1:0] = irq_mask_r;
      default:          d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_mux

  // latch write address, sample read data in address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_r <= acc && hwrite;
      if (acc) begin
        wr_addr_r <= {haddr[7:2], 2'b00};
      end
      if (acc && !hwrite) begin
        hrdata <= read_mux({haddr[7:2], 2'b00});
      end
    end
  end

  // wake status: set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_status_reg_r <= `LB_RST_STS;
    end else if (bpor || battery_low_event) begin
      wake_status_reg_r <= 1'b1;
    end else if (wr_wake_sts && hwdata[`LB_BIT_LOWBAT]) begin
      wake_status_reg_r <= 1'b0;
    end
  end

  // smi status: set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smi_status_reg_r <= `LB_RST_STS;
    end else if (bpor || battery_low_event) begin
      smi_status_reg_r <= 1'b1;
    end else if (wr_smi_sts && hwdata[`LB_BIT_LOWBAT]) begin
      smi_status_reg_r <= 1'b0;
    end
  end

  // wake enables, lost at standby power-on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_en_r <= `LB_RST_EN;
    end else if (standby_por) begin
      wake_en_r <= `LB_RST_EN;
    end else if (wr_wake_en) begin
      wake_en_r <= hwdata[1:0];
    end
  end

  // smi enables kept across main power loss
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smi_en_r <= `LB_RST_EN;
    end else if (wr_smi_en) begin
      smi_en_r <= hwdata[1:0];
    end
  end

  // host events, only with main power up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_event <= 1'b0;
      smi_event  <= 1'b0;
    end else begin
      wake_event <= (mode_r == low_battery_pkg::PM_MAIN) && wake_status_reg_r
                    && wake_en_r[`LB_BIT_LOWBAT] && wake_en_r[`LB_BIT_GROUP_EN];
      smi_event  <= (mode_r == low_battery_pkg::PM_MAIN) && smi_status_reg_r
                    && smi_en_r[`LB_BIT_LOWBAT] && smi_en_r[`LB_BIT_GROUP_EN];
    end
  end

  // battery por marker pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      battery_por <= 1'b0;
    end else begin
      battery_por <= bpor;
    end
  end

  // interrupt status, set wins over clear
  assign irq_set = {battery_low_event, bpor};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sts_r <= `LB_RST_IRQ;
    end else if (wr_irq_sts) begin
      irq_sts_r <= (irq_sts_r & ~hwdata[1:0]) | irq_set;
    end else begin
      irq_sts_r <= irq_sts_r | irq_set;
    end
  end

  // interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= `LB_RST_IRQ;
    end else if (wr_irq_mask) begin
      irq_mask_r <= hwdata[1:0];
    end
  end

  assign irq = |(irq_sts_r & irq_mask_r);

  // checks
  property p_bpor_on_standby_por;
    @(posedge hclk) disable iff (!hresetn)
      standby_por && low_lower_seen_r |=> battery_por;
  endproperty
  a_bpor_on_standby_por: assert property (p_bpor_on_standby_por)
    else $error("battery por missing after standby por");

  property p_bpor_sets_both;
    @(posedge hclk) disable iff (!hresetn)
      bpor |=> wake_status_reg_r && smi_status_reg_r;
  endproperty
  a_bpor_sets_both: assert property (p_bpor_sets_both)
    else $error("battery por did not set both status bits");

  property p_main_por_latches;
    @(posedge hclk) disable iff (!hresetn)
      main_por && low_upper_seen_r |=> wake_status_reg_r && smi_status_reg_r && !low_upper_seen_r;
  endproperty
  a_main_por_latches: assert property (p_main_por_latches)
    else $error("main por did not latch low battery");

  property p_wake_en_cleared;
    @(posedge hclk) disable iff (!hresetn)
      standby_por |=> wake_en_r == 2'h0;
  endproperty
  a_wake_en_cleared: assert property (p_wake_en_cleared)
    else $error("wake enable survived standby por");

  property p_no_wake_off_main;
    @(posedge hclk) disable iff (!hresetn)
      mode_r != low_battery_pkg::PM_MAIN |=> !wake_event;
  endproperty
  a_no_wake_off_main: assert property (p_no_wake_off_main)
    else $error("wake event off main power");

  property p_smi_needs_enables;
    @(posedge hclk) disable iff (!hresetn)
      smi_event |-> $past(smi_status_reg_r) && $past(smi_en_r) == 2'h3;
  endproperty
  a_smi_needs_enables: assert property (p_smi_needs_enables)
    else $error("smi raised without status and enables");

  property p_smi_on_return;
    @(posedge hclk) disable iff (!hresetn)
      mode_r == low_battery_pkg::PM_MAIN && smi_status_reg_r && smi_en_r == 2'h3
      ##1 mode_r == low_battery_pkg::PM_MAIN |-> smi_event;
  endproperty
  a_smi_on_return: assert property (p_smi_on_return)
    else $error("smi not raised on main power");

  property p_set_only_at_por;
    @(posedge hclk) disable iff (!hresetn)
      $rose(smi_status_reg_r) |-> $past(bpor) || $past(battery_low_event);
  endproperty
  a_set_only_at_por: assert property (p_set_only_at_por)
    else $error("status set outside power-on reset");

  property p_event_only_main_por;
    @(posedge hclk) disable iff (!hresetn)
      battery_low_event |-> mode_r == low_battery_pkg::PM_STANDBY ##1 mode_r == low_battery_pkg::PM_MAIN;
  endproperty
  a_event_only_main_por: assert property (p_event_only_main_por)
    else $error("battery low event outside main por");

  property p_w1c_clears;
    @(posedge hclk) disable iff (!hresetn)
      wr_wake_sts && hwdata[0] && !bpor && !battery_low_event |=> !wake_status_reg_r;
  endproperty
  a_w1c_clears: assert property (p_w1c_clears)
    else $error("write one did not clear wake status");

  property p_read_smi_en;
    @(posedge hclk) disable iff (!hresetn)
      acc && !hwrite && haddr[7:0] == `LB_OFF_SMI_EN |=> hrdata[1:0] == $past(smi_en_r);
  endproperty
  a_read_smi_en: assert property (p_read_smi_en)
    else $error("smi enable read mismatch");

  property p_sync_delay;
    @(posedge hclk) disable iff (!hresetn)
      $rose(below_upper_s) |-> $past(battery_below_upper, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("comparator level not two flops late");

endmodule : low_battery_event_logic

// ### chipset_event_model.sv
`timescale 1ns/10ps

// chipset side: counts wake and smi requests and battery reset pulses
module chipset_event_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic wake_event,
  input  wire logic smi_event,
  input  wire logic battery_por,
  output int        wake_rises,
  output int        smi_rises,
  output int        bpor_pulses
);
  logic wake_d_r;
  logic smi_d_r;

  // edge detection of the request levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_d_r    <= 1'b0;
      smi_d_r     <= 1'b0;
      wake_rises  <= 0;
      smi_rises   <= 0;
      bpor_pulses <= 0;
    end else begin
      wake_d_r <= wake_event;
      smi_d_r  <= smi_event;
      if (wake_event === 1'b1 && wake_d_r !== 1'b1) wake_rises <= wake_rises + 1;
      if (smi_event === 1'b1 && smi_d_r !== 1'b1) smi_rises <= smi_rises + 1;
      if (battery_por === 1'b1) bpor_pulses <= bpor_pulses + 1;
    end
  end
endmodule : chipset_event_model

// ### low_battery_event_logic_test.sv
`timescale 1ns/10ps
`include "low_battery_params.svh"

module low_battery_event_logic_test;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        below_upper = 1'b1;
  logic        below_lower = 1'b1;
  logic        standby_good = 1'b0;
  logic        main_good = 1'b0;
  logic        wake_event;
  logic        smi_event;
  logic        battery_por;
  logic        irq;
  int          wake_rises;
  int          smi_rises;
  int          bpor_pulses;
  int          errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic [31:0] reset_exp [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h33, 32'h0, 32'h0, 32'h0};

  // clock and single-slave ready loop
  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;

  low_battery_event_logic uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .battery_below_upper(below_upper),
    .battery_below_lower(below_lower), .standby_power_good(standby_good),
    .main_power_good(main_good), .wake_event(wake_event), .smi_event(smi_event),
    .battery_por(battery_por), .irq(irq)
  );

  chipset_event_model partner (
    .hclk(hclk), .hresetn(hresetn), .wake_event(wake_event), .smi_event(smi_event),
    .battery_por(battery_por), .wake_rises(wake_rises), .smi_rises(smi_rises),
    .bpor_pulses(bpor_pulses)
  );

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      $display("mismatch timeout expected 0 seen %0d", cycles);
      tally_and_finish();
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // single nonseq transfer, address then data phase
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    chk(name, exp, rd);
    chk("hresp", 32'h00000000, {31'h0, hresp});
  endtask : rchk

  task cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : cyc

  task outs(input logic w, input logic s, input logic i);
    #1;
    chk("wake_event", {31'h0, w}, {31'h0, wake_event});
    chk("smi_event", {31'h0, s}, {31'h0, smi_event});
    chk("irq", {31'h0, i}, {31'h0, irq});
  endtask : outs

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and unmapped word
    for (int k = 0; k < 8; k++) begin
      rchk("reset value", 8'(k * 4), reset_exp[k]);
    end
    outs(1'b0, 1'b0, 1'b0);
    $display("test reset done");
    // battery reset at standby arrival, wake enable lost
    ahb(1'b1, `LB_OFF_WAKE_EN, 32'h00000003);
    ahb(1'b1, `LB_OFF_SMI_EN, 32'h00000003);
    @(posedge hclk);
    standby_good <= 1'b1;
    cyc(8);
    chk("battery_por pulses", 32'h1, 32'(bpor_pulses));
    outs(1'b0, 1'b0, 1'b0);
    rchk("wake status", `LB_OFF_WAKE_STS, 32'h1);
    rchk("smi status", `LB_OFF_SMI_STS, 32'h1);
    rchk("wake enable", `LB_OFF_WAKE_EN, 32'h0);
    rchk("smi enable", `LB_OFF_SMI_EN, 32'h3);
    rchk("irq status", `LB_OFF_IRQ_STS, 32'h1);
    // mask bits set to one let the status through to irq
    ahb(1'b1, `LB_OFF_IRQ_MASK, 32'h00000003);
    outs(1'b0, 1'b0, 1'b1);
    ahb(1'b1, `LB_OFF_IRQ_STS, 32'h00000001);
    outs(1'b0, 1'b0, 1'b0);
    rchk("irq status cleared", `LB_OFF_IRQ_STS, 32'h00000000);
    $display("test battery reset done");
    // clear, partial wake enable, then main arrival
    ahb(1'b1, `LB_OFF_WAKE_STS, 32'h00000001);
    ahb(1'b1, `LB_OFF_SMI_STS, 32'h00000001);
    rchk("wake status cleared", `LB_OFF_WAKE_STS, 32'h0);
    rchk("smi status cleared", `LB_OFF_SMI_STS, 32'h0);
    ahb(1'b1, `LB_OFF_WAKE_EN, 32'h00000001);
    @(posedge hclk);
    main_good <= 1'b1;
    cyc(8);
    rchk("wake status main", `LB_OFF_WAKE_STS, 32'h1);
    rchk("smi status main", `LB_OFF_SMI_STS, 32'h1);
    rchk("irq status main", `LB_OFF_IRQ_STS, 32'h2);
    outs(1'b0, 1'b1, 1'b1);
    ahb(1'b1, `LB_OFF_WAKE_EN, 32'h00000003);
    cyc(3);
    outs(1'b1, 1'b1, 1'b1);
    ahb(1'b0, `LB_OFF_POWER, 32'h00000000);
    chk("power levels", 32'h0000000F, rd);
    $display("test main arrival done");
    // no status while on main power
    ahb(1'b1, `LB_OFF_WAKE_STS, 32'h00000001);
    ahb(1'b1, `LB_OFF_SMI_STS, 32'h00000001);
    ahb(1'b1, `LB_OFF_IRQ_STS, 32'h00000003);
    @(posedge hclk);
    below_upper <= 1'b0;
    cyc(4);
    @(posedge hclk);
    below_upper <= 1'b1;
    cyc(8);
    rchk("wake status on main", `LB_OFF_WAKE_STS, 32'h0);
    rchk("smi status on main", `LB_OFF_SMI_STS, 32'h0);
    outs(1'b0, 1'b0, 1'b0);
    $display("test main power done");
    // main lost and regained with enables kept
    @(posedge hclk);
    main_good <= 1'b0;
    cyc(8);
    outs(1'b0, 1'b0, 1'b0);
    rchk("wake status standby", `LB_OFF_WAKE_STS, 32'h0);
    @(posedge hclk);
    main_good <= 1'b1;
    cyc(8);
    outs(1'b1, 1'b1, 1'b1);
    chk("wake requests", 32'h2, 32'(wake_rises));
    chk("smi requests", 32'h2, 32'(smi_rises));
    $display("test main return done");
    tally_and_finish();
  end
endmodule : low_battery_event_logic_test
